// file: logic/artc_top.sv
// two reload/capture timers behind an AXI4-Lite slave with a shared interrupt
// assumes a single-clock system; count and trigger pins are asynchronous to clk_i
`timescale 1ns/1ps
`default_nettype none

module artc_top
	import artc_pkg::*;
#(
	parameter int unsigned TICK_DIV = ARTC_TICK_DIV
) (
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire logic [ARTC_NUM_TIMERS-1:0] count_pin_i,
	input  wire logic [ARTC_NUM_TIMERS-1:0] trigger_pin_i,
	input  wire logic [ARTC_ADDR_W-1:0]     s_axi_awaddr_i,
	input  wire logic                       s_axi_awvalid_i,
	output logic                            s_axi_awready_o,
	input  wire logic [31:0]                s_axi_wdata_i,
	input  wire logic [3:0]                 s_axi_wstrb_i,
	input  wire logic                       s_axi_wvalid_i,
	output logic                            s_axi_wready_o,
	output logic [1:0]                      s_axi_bresp_o,
	output logic                            s_axi_bvalid_o,
	input  wire logic                       s_axi_bready_i,
	input  wire logic [ARTC_ADDR_W-1:0]     s_axi_araddr_i,
	input  wire logic                       s_axi_arvalid_i,
	output logic                            s_axi_arready_o,
	output logic [31:0]                     s_axi_rdata_o,
	output logic [1:0]                      s_axi_rresp_o,
	output logic                            s_axi_rvalid_o,
	input  wire logic                       s_axi_rready_i,
	output logic                            irq_o
);

	function automatic artc_dec_type artc_decode(input logic [ARTC_ADDR_W-1:0] addr);
		artc_dec_type             d;
		logic [ARTC_ADDR_W-1:0]   off;
		d.sel = ARTC_REG_NONE;
		d.tmr = addr[ARTC_TMR_BIT];
		off   = addr & (ARTC_TIMER_STRIDE - 8'h01);
		if (addr[1:0] != 2'b00) begin
			d.sel = ARTC_REG_NONE;
		end else if (addr == ARTC_OFF_IRQ_STATUS) begin
			d.sel = ARTC_REG_IRQ_STATUS;
		end else if (addr == ARTC_OFF_IRQ_MASK) begin
			d.sel = ARTC_REG_IRQ_MASK;
		end else if (addr < ARTC_OFF_IRQ_STATUS) begin
			if (off == ARTC_OFF_CTRL) begin
				d.sel = ARTC_REG_CTRL;
			end else if (off == ARTC_OFF_RCV) begin
				d.sel = ARTC_REG_RCV;
			end else if (off == ARTC_OFF_COUNT) begin
				d.sel = ARTC_REG_COUNT;
			end
		end
		return d;
	endfunction : artc_decode

	function automatic logic [31:0] artc_merge(input logic [31:0] old_v,
	                                           input logic [31:0] new_v,
	                                           input logic [3:0]  strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : artc_merge

	artc_ctrl_type          ctrl_q [ARTC_NUM_TIMERS];
	artc_swr_type           swr    [ARTC_NUM_TIMERS];
	logic [15:0]            count_w [ARTC_NUM_TIMERS];
	logic [15:0]            rcv_w   [ARTC_NUM_TIMERS];
	logic [ARTC_NUM_TIMERS-1:0] reload_evt;
	logic [ARTC_NUM_TIMERS-1:0] capture_evt;

	logic [ARTC_IRQ_W-1:0]  irq_status_q;
	logic [ARTC_IRQ_W-1:0]  irq_status_d;
	logic [ARTC_IRQ_W-1:0]  irq_mask_q;
	logic [ARTC_IRQ_W-1:0]  irq_set;
	logic [ARTC_IRQ_W-1:0]  irq_clr;

	logic                   aw_got_q;
	logic                   w_got_q;
	logic [ARTC_ADDR_W-1:0] awaddr_q;
	logic [31:0]            wdata_q;
	logic [3:0]             wstrb_q;
	logic                   do_write;
	artc_dec_type           wdec;
	artc_dec_type           rdec;
	logic [31:0]            rd_value;
	logic [31:0]            wr_ctrl_v;
	logic [31:0]            wr_half_v;
	logic [31:0]            wr_irq_v;

	// write channel: address and data are taken in either order, one write at a time
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_awready_o <= 1'b0;
			aw_got_q        <= 1'b0;
			awaddr_q        <= '0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				s_axi_awready_o <= 1'b0;
				aw_got_q        <= 1'b1;
				awaddr_q        <= s_axi_awaddr_i;
			end else if (do_write) begin
				aw_got_q <= 1'b0;
			end else if (!aw_got_q && !s_axi_bvalid_o) begin
				s_axi_awready_o <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_wready_o <= 1'b0;
			w_got_q        <= 1'b0;
			wdata_q        <= 32'h0000_0000;
			wstrb_q        <= 4'h0;
		end else begin
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				s_axi_wready_o <= 1'b0;
				w_got_q        <= 1'b1;
				wdata_q        <= s_axi_wdata_i;
				wstrb_q        <= s_axi_wstrb_i;
			end else if (do_write) begin
				w_got_q <= 1'b0;
			end else if (!w_got_q && !s_axi_bvalid_o) begin
				s_axi_wready_o <= 1'b1;
			end
		end
	end

	assign do_write = aw_got_q & w_got_q & ~s_axi_bvalid_o;
	assign wdec     = artc_decode(awaddr_q);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= ARTC_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= (wdec.sel == ARTC_REG_NONE) ? ARTC_RESP_SLVERR : ARTC_RESP_OKAY;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// read channel: data registered on the edge that takes the address
	assign rdec = artc_decode(s_axi_araddr_i);

	always_comb begin
		rd_value = 32'h0000_0000;
		unique case (rdec.sel)
			ARTC_REG_CTRL:       rd_value = {{(32-ARTC_CTRL_W){1'b0}}, ctrl_q[rdec.tmr]};
			ARTC_REG_RCV:        rd_value = {16'h0000, rcv_w[rdec.tmr]};
			ARTC_REG_COUNT:      rd_value = {16'h0000, count_w[rdec.tmr]};
			ARTC_REG_IRQ_STATUS: rd_value = {{(32-ARTC_IRQ_W){1'b0}}, irq_status_q};
			ARTC_REG_IRQ_MASK:   rd_value = {{(32-ARTC_IRQ_W){1'b0}}, irq_mask_q};
			default:             rd_value = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= ARTC_RESP_OKAY;
		end else begin
			if (s_axi_arvalid_i && s_axi_arready_o) begin
				s_axi_arready_o <= 1'b0;
				s_axi_rvalid_o  <= 1'b1;
				s_axi_rdata_o   <= rd_value;
				s_axi_rresp_o   <= (rdec.sel == ARTC_REG_NONE) ? ARTC_RESP_SLVERR
				                                               : ARTC_RESP_OKAY;
			end else if (s_axi_rvalid_o) begin
				if (s_axi_rready_i) begin
					s_axi_rvalid_o <= 1'b0;
				end
			end else begin
				s_axi_arready_o <= 1'b1;
			end
		end
	end

	// write data merged under the byte strobes into the current value of ctrl, rcv, count and mask; the status clear uses no strobes
	assign wr_ctrl_v = artc_merge({{(32-ARTC_CTRL_W){1'b0}}, ctrl_q[wdec.tmr]}, wdata_q, wstrb_q);
	assign wr_half_v = artc_merge({16'h0000, (wdec.sel == ARTC_REG_RCV) ? rcv_w[wdec.tmr]
	                                                                    : count_w[wdec.tmr]},
	                              wdata_q, wstrb_q);
	assign wr_irq_v  = artc_merge({{(32-ARTC_IRQ_W){1'b0}}, irq_mask_q}, wdata_q, wstrb_q);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int t = 0; t < ARTC_NUM_TIMERS; t++) begin
				ctrl_q[t] <= ARTC_CTRL_RST;
			end
			irq_mask_q <= ARTC_IRQ_RST;
		end else if (do_write) begin
			if (wdec.sel == ARTC_REG_CTRL) begin
				ctrl_q[wdec.tmr] <= artc_ctrl_type'(wr_ctrl_v[ARTC_CTRL_W-1:0]);
			end
			if (wdec.sel == ARTC_REG_IRQ_MASK) begin
				irq_mask_q <= wr_irq_v[ARTC_IRQ_W-1:0];
			end
		end
	end

	// both instances are the same core, each with its own pins and registers
	for (genvar t = 0; t < ARTC_NUM_TIMERS; t++) begin : g_timer
		assign swr[t].rcv_wr   = do_write & (wdec.sel == ARTC_REG_RCV) & (wdec.tmr == t);
		assign swr[t].count_wr = do_write & (wdec.sel == ARTC_REG_COUNT) & (wdec.tmr == t);
		assign swr[t].wdata    = wr_half_v[15:0];

		artc_core #(
			.TICK_DIV (TICK_DIV)
		) u_core (
			.clk_i         (clk_i),
			.rst_i         (rst_i),
			.ctrl_i        (ctrl_q[t]),
			.swr_i         (swr[t]),
			.count_pin_i   (count_pin_i[t]),
			.trigger_pin_i (trigger_pin_i[t]),
			.count_o       (count_w[t]),
			.rcv_o         (rcv_w[t]),
			.reload_evt_o  (reload_evt[t]),
			.capture_evt_o (capture_evt[t])
		);

		assign irq_set[2*t]   = reload_evt[t];
		assign irq_set[2*t+1] = capture_evt[t];
	end

	// strobes are ignored in the clear so a one in any lane clears its bit
	assign irq_clr = (do_write && wdec.sel == ARTC_REG_IRQ_STATUS)
	                 ? wdata_q[ARTC_IRQ_W-1:0] : ARTC_IRQ_RST;

	// an event in the cycle of its clear keeps the bit set
	assign irq_status_d = (irq_status_q & ~irq_clr) | irq_set;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_status_q <= ARTC_IRQ_RST;
		end else begin
			irq_status_q <= irq_status_d;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_status_q & irq_mask_q);
		end
	end

endmodule : artc_top

`default_nettype wire

// file: logic/artc_pkg.sv
// constants, field layouts and carrier types of the two-instance reload/capture timer
// assumes one 10 MHz system clock and an AXI4-Lite master with 32-bit data
`default_nettype none

package artc_pkg;

	localparam int unsigned ARTC_NUM_TIMERS = 2;
	localparam int unsigned ARTC_CNT_W      = 16;
	localparam int unsigned ARTC_TICK_DIV   = 12;
	localparam int unsigned ARTC_DIV_W      = 4;
	localparam int unsigned ARTC_ADDR_W     = 8;
	localparam int unsigned ARTC_CTRL_W     = 6;
	localparam int unsigned ARTC_IRQ_W      = 2 * ARTC_NUM_TIMERS;
	localparam int unsigned ARTC_TMR_BIT    = 4;

	localparam logic [15:0] ARTC_CNT_MAX   = 16'hffff;
	localparam logic [15:0] ARTC_CNT_ZERO  = 16'h0000;
	localparam logic [15:0] ARTC_RCV_RST   = 16'h0000;
	localparam logic [15:0] ARTC_COUNT_RST = 16'h0000;

	// per-timer offsets relative to the timer's window, then the stride and the absolute addresses of the shared interrupt registers
	localparam logic [7:0] ARTC_OFF_CTRL       = 8'h00;
	localparam logic [7:0] ARTC_OFF_RCV        = 8'h04;
	localparam logic [7:0] ARTC_OFF_COUNT      = 8'h08;
	localparam logic [7:0] ARTC_TIMER_STRIDE   = 8'h10;
	localparam logic [7:0] ARTC_OFF_IRQ_STATUS = 8'h20;
	localparam logic [7:0] ARTC_OFF_IRQ_MASK   = 8'h24;

	// bit 0 run, 1 counter mode, 2 capture mode, 3 up/down, 4 trigger enable, 5 rising edge
	typedef struct packed {
		logic trig_rise;
		logic trig_en;
		logic updown;
		logic capture_mode;
		logic counter_mode;
		logic run;
	} artc_ctrl_type;

	localparam artc_ctrl_type ARTC_CTRL_RST = '0;
	localparam logic [ARTC_IRQ_W-1:0] ARTC_IRQ_RST = '0;

	typedef enum logic [2:0] {
		ARTC_REG_CTRL       = 3'b000,
		ARTC_REG_RCV        = 3'b001,
		ARTC_REG_COUNT      = 3'b010,
		ARTC_REG_IRQ_STATUS = 3'b011,
		ARTC_REG_IRQ_MASK   = 3'b100,
		ARTC_REG_NONE       = 3'b111
	} artc_reg_type;

	typedef struct packed {
		artc_reg_type sel;
		logic         tmr;
	} artc_dec_type;

	typedef enum logic [1:0] {
		ARTC_RESP_OKAY   = 2'b00,
		ARTC_RESP_SLVERR = 2'b10
	} artc_resp_type;

	typedef struct packed {
		logic        rcv_wr;
		logic        count_wr;
		logic [15:0] wdata;
	} artc_swr_type;

endpackage : artc_pkg

`default_nettype wire

// file: logic/artc_core.sv
// one 16-bit reload/capture timer: prescaler, pin synchronisers, count and value registers
// assumes pins are asynchronous; software writes arrive as one-cycle strobes on clk_i
`timescale 1ns/1ps
`default_nettype none

module artc_core
	import artc_pkg::*;
#(
	parameter int unsigned TICK_DIV = ARTC_TICK_DIV
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire artc_ctrl_type ctrl_i,
	input  wire artc_swr_type  swr_i,
	input  wire logic          count_pin_i,
	input  wire logic          trigger_pin_i,
	output logic [15:0]        count_o,
	output logic [15:0]        rcv_o,
	output logic               reload_evt_o,
	output logic               capture_evt_o
);

	localparam logic [ARTC_DIV_W-1:0] DIV_LAST = ARTC_DIV_W'(TICK_DIV - 1);

	logic [2:0]            cnt_sync_q;
	logic [2:0]            trg_sync_q;
	logic [ARTC_DIV_W-1:0] div_q;
	logic                  count_fall;
	logic                  trg_edge;
	logic                  trg_level;
	logic                  advance;
	logic                  trig_reload;
	logic                  capture;
	logic                  at_max;

	// stage 0 feeds only stage 1; edges are judged between stages 1 and 2
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_sync_q <= 3'h0;
			trg_sync_q <= 3'h0;
		end else begin
			cnt_sync_q <= {cnt_sync_q[1:0], count_pin_i};
			trg_sync_q <= {trg_sync_q[1:0], trigger_pin_i};
		end
	end

	assign count_fall = cnt_sync_q[2] & ~cnt_sync_q[1];
	assign trg_level  = trg_sync_q[1];
	assign trg_edge   = ctrl_i.trig_rise ? (trg_sync_q[1] & ~trg_sync_q[2])
	                                     : (trg_sync_q[2] & ~trg_sync_q[1]);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_q <= '0;
		end else if (!ctrl_i.run || ctrl_i.counter_mode || div_q == DIV_LAST) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	// pins may toggle faster than one per 24 clocks, but only that rate is promised
	assign advance = ctrl_i.run & (ctrl_i.counter_mode ? count_fall : (div_q == DIV_LAST));
	assign at_max  = (count_o == ARTC_CNT_MAX);
	assign trig_reload = ctrl_i.run & ~ctrl_i.capture_mode & ~ctrl_i.updown
	                     & ctrl_i.trig_en & trg_edge;
	assign capture = ctrl_i.run & ctrl_i.capture_mode & ctrl_i.trig_en & trg_edge;

	// a software write to the count wins over counting in the same cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_o <= ARTC_COUNT_RST;
		end else if (swr_i.count_wr) begin
			count_o <= swr_i.wdata;
		end else if (ctrl_i.capture_mode) begin
			if (advance) begin
				count_o <= at_max ? ARTC_CNT_ZERO : count_o + 16'h0001;
			end
		end else if (trig_reload) begin
			count_o <= rcv_o;
		end else if (advance) begin
			if (ctrl_i.updown && !trg_level) begin
				count_o <= (count_o == rcv_o) ? ARTC_CNT_MAX : count_o - 16'h0001;
			end else begin
				count_o <= at_max ? rcv_o : count_o + 16'h0001;
			end
		end
	end

	// hardware capture wins over a software write in the same cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rcv_o <= ARTC_RCV_RST;
		end else if (capture) begin
			rcv_o <= count_o;
		end else if (swr_i.rcv_wr) begin
			rcv_o <= swr_i.wdata;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			reload_evt_o  <= 1'b0;
			capture_evt_o <= 1'b0;
		end else begin
			// capture mode ignores the up/down bit, so its overflows must still interrupt
			reload_evt_o  <= ~swr_i.count_wr & ~(ctrl_i.updown & ~ctrl_i.capture_mode)
			                 & (trig_reload | (advance & at_max));
			capture_evt_o <= capture;
		end
	end

endmodule : artc_core

`default_nettype wire

// file: tb/artc_checker.sv
// bus handshake and interrupt checks on the ports of the two-timer block
// assumes it is bound to artc_top; single clock, asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module artc_checker (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0]  s_axi_rresp_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	input wire logic        irq_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	AST_B_AFTER: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
		&& s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o) else $error("write response missing");
	AST_B_DROP: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
		else $error("write response not released");
	AST_B_CODE: assert property (s_axi_bvalid_o |-> s_axi_bresp_o inside {2'b00, 2'b10})
		else $error("bad write response code");
	AST_AW_BLOCK: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write taken while response pending");
	AST_R_AFTER: assert property (s_axi_arvalid_i && s_axi_arready_o |-> ##[1:2] s_axi_rvalid_o)
		else $error("read data missing");
	AST_R_DROP: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
		else $error("read data not released");
	AST_AR_BLOCK: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("read taken while data pending");
	AST_ERR_ZERO: assert property (s_axi_rvalid_o && s_axi_rresp_o == 2'b10
		|-> s_axi_rdata_o == 32'h0) else $error("error read returns data");
	// only a status clear or mask write can take the interrupt away
	AST_IRQ_FALL: assert property ($fell(irq_o) |->
		$past(s_axi_bvalid_o) || $past(s_axi_bvalid_o, 2)) else $error("irq fell without write");
endmodule : artc_checker

`default_nettype wire

// file: tb/artc_pin_model.sv
// model of the external count and trigger pins of both timers
// assumes requests arrive as one-cycle pulses on clk_i; no reset needed
`timescale 1ns/1ps
`default_nettype none

module artc_pin_model #(
	parameter int unsigned HALF = 12
) (
	input  wire logic       clk_i,
	input  wire logic [1:0] fall_req_i,
	input  wire logic [1:0] trig_lvl_i,
	output logic      [1:0] count_pin_o,
	output logic      [1:0] trigger_pin_o,
	output logic      [1:0] busy_o
);
	int cnt_q [2];

	initial count_pin_o = 2'b11;
	initial cnt_q = '{0, 0};
	// trigger is a level pin; it also carries the up/down direction
	assign trigger_pin_o = trig_lvl_i;
	assign busy_o = {cnt_q[1] != 0, cnt_q[0] != 0};

	// each fall is held low then high for HALF clocks, one fall per 2*HALF clocks at most
	always @(posedge clk_i) begin
		for (int t = 0; t < 2; t++) begin
			if (cnt_q[t] != 0) begin
				cnt_q[t] <= cnt_q[t] - 1;
				if (cnt_q[t] == HALF + 1) count_pin_o[t] <= 1'b1;
			end else if (fall_req_i[t]) begin
				count_pin_o[t] <= 1'b0;
				cnt_q[t] <= 2 * HALF;
			end
		end
	end
endmodule : artc_pin_model

`default_nettype wire

// file: tb/test_autoreload_capture_timer16.sv
// self-checking bench for the two reload/capture timers behind the register bus
// assumes artc_top with a shortened tick divider, the pin model and the bound checker
`timescale 1ns/1ps
`default_nettype none

module test_autoreload_capture_timer16;
	import artc_pkg::*;

	localparam int unsigned TICK = 3;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [1:0]  fall_req = 2'b00, trig_lvl = 2'b11, cpin, tpin, busy;
	logic [7:0]  awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, r_data, rd_data;
	logic [3:0]  wstrb = '0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, irq;
	logic [1:0]  b_resp, r_resp, last_resp, rd_resp;
	int          bad_count = 0;
	int          n_compared = 0;

	always #50 clk_i = ~clk_i;

	artc_pin_model #(.HALF(12)) u_pins (.clk_i(clk_i), .fall_req_i(fall_req),
		.trig_lvl_i(trig_lvl), .count_pin_o(cpin), .trigger_pin_o(tpin), .busy_o(busy));

	artc_top #(.TICK_DIV(TICK)) dut (.clk_i(clk_i), .rst_i(rst_i), .count_pin_i(cpin),
		.trigger_pin_i(tpin), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(aw_rdy), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(w_rdy), .s_axi_bresp_o(b_resp),
		.s_axi_bvalid_o(b_vld), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
		.s_axi_arvalid_i(arvalid), .s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_data),
		.s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_vld), .s_axi_rready_i(rready), .irq_o(irq));

	task automatic miss(input string m);
		$display("MISMATCH %0t %s", $time, m);
		bad_count++;
	endtask : miss

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) miss($sformatf("got %h expected %h", got, exp));
	endtask : cmp_word

	task automatic cmp_range(input logic [31:0] got, input int lo, input int hi);
		n_compared++;
		if ($isunknown(got) || got < lo || got > hi)
			miss($sformatf("got %0d outside %0d..%0d", got, lo, hi));
	endtask : cmp_range

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
		int n;
		n = 0;
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			if (awvalid && aw_rdy) awvalid <= 1'b0;
			if (wvalid && w_rdy) wvalid <= 1'b0;
		end while (!b_vld && n < 200);
		last_resp = b_resp;
		bready <= 1'b0;
		if (n >= 200) miss("write timeout");
	endtask : wr

	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
			if (arvalid && ar_rdy) arvalid <= 1'b0;
		end while (!r_vld && n < 200);
		rd_data = r_data;
		rd_resp = r_resp;
		rready <= 1'b0;
		if (n >= 200) miss("read timeout");
	endtask : rd

	task automatic check(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		cmp_word(rd_data, e);
	endtask : check

	// the pin model spaces falls itself; wait it out plus the synchroniser delay
	task automatic fall(input int t);
		while (busy[t]) @(posedge clk_i);
		@(posedge clk_i);
		fall_req[t] <= 1'b1;
		@(posedge clk_i);
		fall_req[t] <= 1'b0;
		repeat (30) @(posedge clk_i);
	endtask : fall

	task automatic set_trig(input int t, input logic v);
		@(posedge clk_i);
		trig_lvl[t] <= v;
		repeat (8) @(posedge clk_i);
	endtask : set_trig

	task automatic print_verdict();
		if (bad_count == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : print_verdict

	initial begin
		repeat (20000) @(posedge clk_i);
		miss("watchdog expired");
		print_verdict();
	end

	initial begin
		logic [7:0] b;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		for (int a = 0; a < 'h28; a += 4) begin
			if (a[3:2] != 2'b11) check(8'(a), 32'h0);
		end
		rd(8'h30);
		cmp_word({30'h0, rd_resp}, 32'h2);
		wr(8'h0c, 32'h1);
		cmp_word({30'h0, last_resp}, 32'h2);
		// up-only overflow reload on each timer, interrupt enabled
		for (int t = 0; t < 2; t++) begin
			b = 8'(16 * t);
			wr(8'h24, 32'h1 << (2 * t));
			wr(b + 8'h04, 32'h1234);
			wr(b + 8'h08, 32'hfffe);
			wr(b, 32'h03);
			fall(t);
			check(b + 8'h08, 32'hffff);
			cmp_word({31'h0, irq}, 32'h0);
			fall(t);
			check(b + 8'h08, 32'h1234);
			check(8'h20, 32'h1 << (2 * t));
			cmp_word({31'h0, irq}, 32'h1);
			wr(8'h20, 32'h1 << (2 * t));
			check(8'h20, 32'h0);
			cmp_word({31'h0, irq}, 32'h0);
			wr(b, 32'h0);
		end
		// trigger reloads, interrupt masked off
		wr(8'h24, 32'h0);
		wr(8'h08, 32'h5);
		wr(8'h00, 32'h03);
		set_trig(0, 1'b0);
		check(8'h08, 32'h5);
		wr(8'h00, 32'h13);
		set_trig(0, 1'b1);
		check(8'h08, 32'h5);
		set_trig(0, 1'b0);
		check(8'h08, 32'h1234);
		check(8'h20, 32'h1);
		cmp_word({31'h0, irq}, 32'h0);
		wr(8'h08, 32'h5);
		wr(8'h00, 32'h33);
		set_trig(0, 1'b1);
		check(8'h08, 32'h1234);
		wr(8'h20, 32'h1);
		// up/down: high counts up, low counts down to the reload value then ffff
		wr(8'h24, 32'hf);
		wr(8'h08, 32'hffff);
		wr(8'h00, 32'h0b);
		fall(0);
		check(8'h08, 32'h1234);
		set_trig(0, 1'b0);
		wr(8'h08, 32'h1235);
		fall(0);
		check(8'h08, 32'h1234);
		fall(0);
		check(8'h08, 32'hffff);
		fall(0);
		check(8'h08, 32'hfffe);
		check(8'h20, 32'h0);
		cmp_word({31'h0, irq}, 32'h0);
		// capture: overflow to zero, then falling edge copies the count
		wr(8'h00, 32'h0);
		wr(8'h08, 32'hffff);
		wr(8'h00, 32'h1f);
		fall(0);
		check(8'h08, 32'h0);
		check(8'h20, 32'h1);
		wr(8'h08, 32'h42);
		set_trig(0, 1'b1);
		check(8'h04, 32'h1234);
		set_trig(0, 1'b0);
		check(8'h04, 32'h42);
		check(8'h20, 32'h3);
		cmp_word({31'h0, irq}, 32'h1);
		// a write with no byte lanes enabled must leave the mask alone
		wr(8'h24, 32'h0, 4'h0);
		check(8'h24, 32'hf);
		cmp_word({31'h0, irq}, 32'h1);
		// timer mode: about one step per TICK clocks over the run window
		wr(8'h00, 32'h0);
		wr(8'h08, 32'h0);
		wr(8'h00, 32'h01);
		repeat (90) @(posedge clk_i);
		wr(8'h00, 32'h0);
		rd(8'h08);
		cmp_range(rd_data, 90 / TICK - 1, 100 / TICK + 2);
		print_verdict();
	end
endmodule : test_autoreload_capture_timer16

bind artc_top artc_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
	.s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
	.s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
	.s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
	.s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
	.s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
	.s_axi_rready_i(s_axi_rready_i), .irq_o(irq_o));

`default_nettype wire
